/* logic/supply_supervisor_watchdog.sv */
// Purpose: supply supervisor, watchdog, reset and chip-enable gating
// Assumes: comparator results arrive as digital levels from the analogue side
// Notes: registers over AXI4-Lite; long counts are parameters for simulation

`timescale 1ns/1ns

module supply_supervisor_watchdog #(
  parameter int unsigned RESET_CYCLES = supervisor_pkg::RESET_TIMEOUT_CYCLES,
  parameter int unsigned WD_FAST_CYCLES = supervisor_pkg::WD_FAST_CYCLES,
  parameter int unsigned WD_SLOW_CYCLES = supervisor_pkg::WD_SLOW_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // comparator results
  input wire logic supply_below_thresh,
  input wire logic supply_below_backup,
  input wire logic powerfail_sense_in,
  // three-level kick input as two comparator levels
  input wire logic watchdog_kick_high,
  input wire logic watchdog_kick_low,
  // timing selection
  input wire logic timing_source_select,
  input wire logic timing_osc_input,
  // memory chip enable
  input wire logic chip_enable_in_n,
  output logic chip_enable_out_n,
  // status pins
  output logic supply_low_flag,
  output logic battery_active_flag,
  output logic powerfail_flag_out,
  output logic watchdog_expired_n,
  // reset outputs; active-high one is open drain
  output logic reset_out_n,
  output logic reset_hi_out,
  output logic reset_hi_oe_n,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [supervisor_pkg::IN_WIDTH-1:0] pins;
  logic [supervisor_pkg::IN_WIDTH-1:0] pins_s;

  assign pins = {chip_enable_in_n, timing_osc_input, timing_source_select,
                 watchdog_kick_low, watchdog_kick_high, powerfail_sense_in,
                 supply_below_backup, supply_below_thresh};

  // start as if supply low so reset holds from power-on
  input_sync #(
    .WIDTH(supervisor_pkg::IN_WIDTH),
    .INIT(8'h81)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(pins),
    .sync_out(pins_s)
  );

  logic sup_low;
  logic ext_timing;
  logic osc_lvl;
  logic ce_in_n;

  assign sup_low = pins_s[supervisor_pkg::IN_SUPPLY_LOW];
  assign ext_timing = ~pins_s[supervisor_pkg::IN_SRC_SEL];
  assign osc_lvl = pins_s[supervisor_pkg::IN_OSC];
  assign ce_in_n = pins_s[supervisor_pkg::IN_CE_N];

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic osc_prev;
  logic tick;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_prev <= 1'b1;
    end else begin
      osc_prev <= osc_lvl;
    end
  end

  // external mode counts osc rising edges, internal counts clk
  assign tick = ext_timing ? (osc_lvl & ~osc_prev) : 1'b1;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic wd_sw_en;

  assign wd_sw_en = ctrl[supervisor_pkg::CTRL_WD_EN_BIT];

  // ----------------------------------------------------------------
  // kick input decode and glitch filter
  // ----------------------------------------------------------------
  supervisor_pkg::kick_level_t kick_raw;
  supervisor_pkg::kick_level_t kick_cand;
  supervisor_pkg::kick_level_t kick_lvl;
  logic [7:0] kick_stable;
  logic kick_change;

  always_comb begin
    if (pins_s[supervisor_pkg::IN_KICK_HIGH]) begin
      kick_raw = supervisor_pkg::KICK_HIGH;
    end else if (pins_s[supervisor_pkg::IN_KICK_LOW]) begin
      kick_raw = supervisor_pkg::KICK_LOW;
    end else begin
      kick_raw = supervisor_pkg::KICK_MID;
    end
  end

  // a new level counts only after it has held the least kick width
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kick_cand <= supervisor_pkg::KICK_MID;
      kick_stable <= 8'h00;
    end else if (kick_raw != kick_cand) begin
      kick_cand <= kick_raw;
      kick_stable <= 8'h00;
    end else if (kick_stable != 8'(supervisor_pkg::KICK_MIN_CYCLES)) begin
      kick_stable <= kick_stable + 8'h01;
    end
  end

  assign kick_change = (kick_stable == 8'(supervisor_pkg::KICK_MIN_CYCLES - 1))
                       && (kick_cand != kick_lvl);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kick_lvl <= supervisor_pkg::KICK_MID;
    end else if (kick_change) begin
      kick_lvl <= kick_cand;
    end
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  logic rst_active;
  logic [31:0] rst_count;
  logic [31:0] rst_limit;
  logic rst_done;
  logic wd_fire;

  assign rst_limit = ext_timing ? supervisor_pkg::EXT_RESET : RESET_CYCLES;
  assign rst_done = rst_active && !sup_low && tick && (rst_count >= rst_limit - 32'd1);

  // battery switchover takes no part here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_active <= 1'b1;
      rst_count <= 32'h0000_0000;
    end else if (sup_low) begin
      rst_active <= 1'b1;
      rst_count <= 32'h0000_0000;
    end else if (wd_fire) begin
      rst_active <= 1'b1;
      rst_count <= 32'h0000_0000;
    end else if (rst_done) begin
      rst_active <= 1'b0;
      rst_count <= 32'h0000_0000;
    end else if (rst_active && tick) begin
      rst_count <= rst_count + 32'd1;
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic wd_active;
  logic wd_post;
  logic [31:0] wd_count;
  logic [31:0] wd_limit;

  // off below threshold, on a floating input, or by software
  assign wd_active = !sup_low && (kick_lvl != supervisor_pkg::KICK_MID)
                     && wd_sw_en;

  always_comb begin
    if (ext_timing) begin
      wd_limit = wd_post ? supervisor_pkg::EXT_WD_POST
                         : supervisor_pkg::EXT_WD_NORMAL;
    end else if (!osc_lvl) begin
      wd_limit = wd_post ? WD_SLOW_CYCLES : WD_FAST_CYCLES;
    end else begin
      wd_limit = WD_SLOW_CYCLES;
    end
  end

  assign wd_fire = wd_active && !rst_active && !kick_change && tick
                   && (wd_count >= wd_limit - 32'd1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wd_count <= 32'h0000_0000;
    end else if (!wd_active || rst_active || kick_change || wd_fire) begin
      wd_count <= 32'h0000_0000;
    end else if (tick) begin
      wd_count <= wd_count + 32'd1;
    end
  end

  // long first interval after every reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wd_post <= 1'b1;
    end else if (rst_active) begin
      wd_post <= 1'b1;
    end else if (kick_change) begin
      wd_post <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_expired_n <= 1'b1;
    end else if (!wd_active) begin
      watchdog_expired_n <= 1'b1;
    end else if (wd_fire) begin
      watchdog_expired_n <= 1'b0;
    end else if (kick_change) begin
      watchdog_expired_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // reset and status pins
  // ----------------------------------------------------------------
  logic rst_now;

  assign rst_now = sup_low || rst_active || wd_fire;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_out_n <= 1'b0;
      reset_hi_oe_n <= 1'b1;
    end else begin
      reset_out_n <= ~rst_now;
      reset_hi_oe_n <= rst_now;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_hi_out <= 1'b0;
    end else begin
      reset_hi_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supply_low_flag <= 1'b0;
      battery_active_flag <= 1'b0;
      powerfail_flag_out <= 1'b1;
    end else begin
      supply_low_flag <= ~sup_low;
      battery_active_flag <= sup_low && pins_s[supervisor_pkg::IN_BELOW_BACKUP];
      powerfail_flag_out <= ~pins_s[supervisor_pkg::IN_PF_BELOW];
    end
  end

  // ----------------------------------------------------------------
  // chip-enable gating
  // ----------------------------------------------------------------
  logic rst_prev;
  logic ce_hold;
  logic [15:0] ce_count;

  // lets a write cycle in flight complete when reset strikes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_prev <= 1'b1;
      ce_hold <= 1'b0;
      ce_count <= 16'h0000;
    end else begin
      rst_prev <= rst_now;
      if (rst_now && !rst_prev && !ce_in_n) begin
        ce_hold <= 1'b1;
        ce_count <= 16'h0000;
      end else if (ce_hold) begin
        if (ce_in_n || !rst_now
            || ce_count == 16'(supervisor_pkg::CE_HOLD_CYCLES - 2)) begin
          ce_hold <= 1'b0;
        end
        ce_count <= ce_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chip_enable_out_n <= 1'b1;
    end else if (!rst_now) begin
      chip_enable_out_n <= ce_in_n;
    end else if ((ce_hold || !rst_prev) && !ce_in_n) begin
      chip_enable_out_n <= 1'b0;
    end else begin
      chip_enable_out_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign do_write = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got <= 1'b0;
      aw_addr <= 4'h0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_got <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_got <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= supervisor_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[3:2] == supervisor_pkg::CTRL_ADDR[3:2])
                     ? supervisor_pkg::RESP_OKAY : supervisor_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only the control word is writable; others answer with an error
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= supervisor_pkg::CTRL_RESET;
    end else if (do_write && aw_addr[3:2] == supervisor_pkg::CTRL_ADDR[3:2]
                 && w_strb[0]) begin
      ctrl <= {31'h0, w_data[supervisor_pkg::CTRL_WD_EN_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [31:0] status;

  always_comb begin
    status = 32'h0000_0000;
    status[supervisor_pkg::ST_SUPPLY_LOW] = sup_low;
    status[supervisor_pkg::ST_BATTERY] = battery_active_flag;
    status[supervisor_pkg::ST_POWERFAIL] = ~powerfail_flag_out;
    status[supervisor_pkg::ST_RESET] = rst_now;
    status[supervisor_pkg::ST_EXPIRED] = ~watchdog_expired_n;
    status[supervisor_pkg::ST_WD_ACTIVE] = wd_active;
    status[supervisor_pkg::ST_POST_RESET] = wd_post;
    status[supervisor_pkg::ST_EXT_TIMING] = ext_timing;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= supervisor_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= supervisor_pkg::RESP_OKAY;
      case (s_axi_araddr[3:2])
        supervisor_pkg::CTRL_ADDR[3:2]: s_axi_rdata <= ctrl;
        supervisor_pkg::STATUS_ADDR[3:2]: s_axi_rdata <= status;
        supervisor_pkg::WD_COUNT_ADDR[3:2]: s_axi_rdata <= wd_count;
        supervisor_pkg::RST_COUNT_ADDR[3:2]: s_axi_rdata <= rst_count;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= supervisor_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : supply_supervisor_watchdog

/* logic/supervisor_pkg.sv */
// Purpose: constants for the supply supervisor and watchdog block
// Assumes: clk at 50 MHz; analogue comparators arrive as digital levels
// Notes: every offset, field position, register reset value and timing count lives here

package supervisor_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 64'd50000000;
  localparam longint RESET_TIMEOUT_MS = 64'd200;
  localparam longint WD_FAST_MS = 64'd100;
  localparam longint WD_SLOW_MS = 64'd1600;
  localparam longint KICK_MIN_NS = 64'd100;
  localparam longint CE_HOLD_US = 64'd16;
  localparam int unsigned RESET_TIMEOUT_CYCLES = 32'(RESET_TIMEOUT_MS * CLK_HZ / 64'd1000);
  localparam int unsigned WD_FAST_CYCLES = 32'(WD_FAST_MS * CLK_HZ / 64'd1000);
  localparam int unsigned WD_SLOW_CYCLES = 32'(WD_SLOW_MS * CLK_HZ / 64'd1000);
  // least time: round up
  localparam int unsigned KICK_MIN_CYCLES =
    32'((KICK_MIN_NS * CLK_HZ + 64'd999999999) / 64'd1000000000);
  // longest time: round down
  localparam int unsigned CE_HOLD_CYCLES = 32'(CE_HOLD_US * CLK_HZ / 64'd1000000);
  // external clock mode counts
  localparam logic [31:0] EXT_WD_NORMAL = 32'h0000_0400;
  localparam logic [31:0] EXT_WD_POST = 32'h0000_1000;
  localparam logic [31:0] EXT_RESET = 32'h0000_0800;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] WD_COUNT_ADDR = 4'h8;
  localparam logic [3:0] RST_COUNT_ADDR = 4'hc;
  localparam int CTRL_WD_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int ST_SUPPLY_LOW = 0;
  localparam int ST_BATTERY = 1;
  localparam int ST_POWERFAIL = 2;
  localparam int ST_RESET = 3;
  localparam int ST_EXPIRED = 4;
  localparam int ST_WD_ACTIVE = 5;
  localparam int ST_POST_RESET = 6;
  localparam int ST_EXT_TIMING = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // synchronised input vector positions
  // ----------------------------------------------------------------
  localparam int IN_SUPPLY_LOW = 0;
  localparam int IN_BELOW_BACKUP = 1;
  localparam int IN_PF_BELOW = 2;
  localparam int IN_KICK_HIGH = 3;
  localparam int IN_KICK_LOW = 4;
  localparam int IN_SRC_SEL = 5;
  localparam int IN_OSC = 6;
  localparam int IN_CE_N = 7;
  localparam int IN_WIDTH = 8;

  // three-level kick input, decoded
  typedef enum logic [1:0] {
    KICK_MID = 2'b00,
    KICK_LOW = 2'b01,
    KICK_HIGH = 2'b11
  } kick_level_t;

endpackage : supervisor_pkg

/* logic/input_sync.sv */
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: each bit is an independent level, no bus coherence
// Notes: only the second stage may be read outside this module

`timescale 1ns/1ns

module input_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : input_sync

/* sim/supervisor_chk.sv */
// Purpose: port-level checker for the supervisor block
// Assumes: pin changes reach outputs three clocks later
// Notes: bound to the design from the bench top
`timescale 1ns/1ns
module supervisor_chk #(
  parameter int unsigned RESET_CYCLES = supervisor_pkg::RESET_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins in
  input wire logic supply_below_thresh,
  input wire logic supply_below_backup,
  input wire logic powerfail_sense_in,
  input wire logic watchdog_kick_high,
  input wire logic watchdog_kick_low,
  input wire logic chip_enable_in_n,
  // pins out
  input wire logic chip_enable_out_n,
  input wire logic supply_low_flag,
  input wire logic battery_active_flag,
  input wire logic powerfail_flag_out,
  input wire logic watchdog_expired_n,
  input wire logic reset_out_n,
  input wire logic reset_hi_oe_n
);
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // counts low cycles so long pulses need no big repetition
  int unsigned low_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_cnt <= 0;
    else if (reset_out_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  sequence sup_low_s;
    supply_below_thresh [*3];
  endsequence
  sequence sup_ok_s;
    !supply_below_thresh [*3];
  endsequence
  sequence mid_s;
    (!watchdog_kick_high && !watchdog_kick_low) [*8];
  endsequence
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  hi_inverse_a: assert property (reset_hi_oe_n == !reset_out_n)
    else $error("high reset not inverse");
  flag_low_a: assert property (sup_low_s |=> !supply_low_flag)
    else $error("supply flag not low");
  flag_high_a: assert property (sup_ok_s |=> supply_low_flag)
    else $error("supply flag not high");
  rst_on_low_a: assert property (sup_low_s |=> !reset_out_n)
    else $error("reset not held");
  expiry_off_a: assert property (sup_low_s |=> watchdog_expired_n)
    else $error("expiry while supply low");
  expiry_mid_a: assert property (mid_s |=> watchdog_expired_n)
    else $error("expiry with floating kick");
  pf_low_a: assert property (powerfail_sense_in [*3] |=> !powerfail_flag_out)
    else $error("powerfail flag high");
  battery_mode_a: assert property ((supply_below_thresh && supply_below_backup) [*3]
    |=> battery_active_flag)
    else $error("battery flag low");
  ce_block_a: assert property (chip_enable_in_n [*3] |=> chip_enable_out_n)
    else $error("chip enable passed");
  rst_len_a: assert property ($rose(reset_out_n) |-> low_cnt >= RESET_CYCLES - 1)
    else $error("reset too short");
  expiry_rst_a: assert property ($fell(watchdog_expired_n) |-> ##[0:1] !reset_out_n [*8])
    else $error("expiry without reset");
  ce_hold_a: assert property ($fell(reset_out_n) && $past(!chip_enable_in_n, 3)
    |-> !chip_enable_out_n)
    else $error("ce cut early");
endmodule : supervisor_chk

/* sim/host_model.sv */
// Purpose: processor side that toggles the kick pin
// Assumes: a processor held in reset does not kick
// Notes: kick_mid floats the pin to its mid level
`timescale 1ns/1ns
module host_model (
  // clock and device reset
  input wire logic clk,
  input wire logic reset_out_n,
  // bench control
  input wire logic kick_en,
  input wire logic kick_mid,
  input wire logic [7:0] kick_period,
  // kick pin as comparator levels
  output logic watchdog_kick_high,
  output logic watchdog_kick_low
);
  logic level = 1'b0;
  logic [7:0] cnt = 8'h00;
  // each level lasts at least period+1 clocks, well over 100ns
  always_ff @(posedge clk) begin
    if (!reset_out_n || !kick_en) cnt <= 8'h00;
    else if (cnt >= kick_period) begin
      cnt <= 8'h00;
      level <= !level;
    end else cnt <= cnt + 8'h01;
  end
  assign watchdog_kick_high = !kick_mid && level;
  assign watchdog_kick_low = !kick_mid && !level;
endmodule : host_model

/* sim/supply_supervisor_watchdog_tb_top.sv */
// Purpose: self-checking bench for the supervisor block
// Assumes: short counts 40/60/200 stand in for the real ones
// Notes: bus results pass through a queue to a watcher
`timescale 1ns/1ns
module supply_supervisor_watchdog_tb_top;
  localparam int RST = 40;
  localparam int SLOW = 200;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic supply_below_thresh = 1'b1, supply_below_backup = 1'b0, powerfail_sense_in = 1'b0;
  logic timing_source_select = 1'b1, timing_osc_input = 1'b0, chip_enable_in_n = 1'b1;
  logic watchdog_kick_high, watchdog_kick_low, chip_enable_out_n, supply_low_flag;
  logic battery_active_flag, powerfail_flag_out, watchdog_expired_n;
  logic reset_out_n, reset_hi_out, reset_hi_oe_n;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic kick_en = 1'b0, kick_mid = 1'b0;
  logic [7:0] kick_period = 8'h10;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'h7d34f478;
  int mismatches = 0, checks = 0, n;
  int lim[2] = '{60, 200};
  supply_supervisor_watchdog #(.RESET_CYCLES(RST), .WD_FAST_CYCLES(60), .WD_SLOW_CYCLES(SLOW))
    u_supply_supervisor_watchdog (.*);
  host_model u_host_model (.*);
  initial forever #10 clk = ~clk;
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic in_span(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : in_span
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  function automatic logic pick(input int w);
    return w == 0 ? reset_out_n : (w == 1 ? watchdog_expired_n : chip_enable_out_n);
  endfunction : pick
  task automatic wait_for(input int w, input logic v, input int lm, output int c);
    c = 0;
    while (pick(w) !== v && c < lm) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_for
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_arvalid || s_axi_rready);
  endtask : axi_rd
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp({s_axi_bresp, 32'h0}, exp_q.pop_front());
  end
  initial begin
    #400000;
    mismatches++;
    final_report();
  end
  // ------------------------------------------------
  // stimulus
  // ------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    tick(10);
    cmp(34'({reset_out_n, reset_hi_oe_n, supply_low_flag}), 34'h2);
    kick_en <= 1'b1;
    supply_below_thresh <= 1'b0;
    wait_for(0, 1'b1, 200, n);
    in_span(n, RST, RST + 6);
    cmp(34'({reset_hi_out, reset_hi_oe_n, supply_low_flag}), 34'h1);
    d = xs() & 32'h1;
    axi_rd(supervisor_pkg::CTRL_ADDR, {supervisor_pkg::RESP_OKAY, supervisor_pkg::CTRL_RESET});
    axi_wr(supervisor_pkg::CTRL_ADDR, d, supervisor_pkg::RESP_OKAY);
    axi_rd(supervisor_pkg::CTRL_ADDR, {supervisor_pkg::RESP_OKAY, d});
    axi_wr(supervisor_pkg::STATUS_ADDR, xs(), supervisor_pkg::RESP_SLVERR);
    axi_rd(4'h2, {supervisor_pkg::RESP_OKAY, d});
    axi_wr(supervisor_pkg::CTRL_ADDR, 32'h1, supervisor_pkg::RESP_OKAY);
    kick_period <= 8'd8 + 8'(xs() % 32);
    wait_for(1, 1'b0, 600, n);
    in_span(n, 600, 600);
    for (int o = 0; o < 2; o++) begin
      timing_osc_input <= o[0];
      kick_period <= 8'd8;
      tick(100);
      kick_en <= 1'b0;
      wait_for(1, 1'b0, 400, n);
      in_span(n, lim[o] - 4, lim[o] + 12);
      wait_for(0, 1'b0, 4, n);
      wait_for(0, 1'b1, 100, n);
      in_span(n, RST - 2, RST + 2);
      cmp(34'(watchdog_expired_n), 34'h0);
      wait_for(0, 1'b0, 400, n);
      in_span(n, SLOW - 2, SLOW + 4);
      wait_for(0, 1'b1, 100, n);
      kick_en <= 1'b1;
      wait_for(1, 1'b1, 100, n);
      in_span(n, 9, 40);
    end
    kick_en <= 1'b0;
    wait_for(1, 1'b0, 300, n);
    kick_mid <= 1'b1;
    wait_for(0, 1'b1, 100, n);
    wait_for(0, 1'b0, 500, n);
    in_span(n, 500, 500);
    cmp(34'(watchdog_expired_n), 34'h1);
    kick_mid <= 1'b0;
    timing_source_select <= 1'b0;
    wait_for(0, 1'b0, 600, n);
    in_span(n, 600, 600);
    timing_source_select <= 1'b1;
    kick_en <= 1'b1;
    tick(20);
    chip_enable_in_n <= 1'b0;
    powerfail_sense_in <= 1'b1;
    supply_below_backup <= 1'b1;
    tick(6);
    cmp(34'({chip_enable_out_n, powerfail_flag_out, battery_active_flag, reset_out_n}),
      34'h1);
    supply_below_thresh <= 1'b1;
    tick(20);
    cmp(34'({chip_enable_out_n, reset_out_n, reset_hi_oe_n, battery_active_flag,
      watchdog_expired_n}), 34'h7);
    wait_for(2, 1'b1, 1000, n);
    in_span(n + 20, 790, 806);
    supply_below_backup <= 1'b0;
    tick(6);
    cmp(34'(battery_active_flag), 34'h0);
    supply_below_thresh <= 1'b0;
    wait_for(0, 1'b1, 200, n);
    in_span(n, RST, RST + 6);
    tick(5);
    supply_below_thresh <= 1'b1;
    tick(10);
    chip_enable_in_n <= 1'b1;
    tick(5);
    chip_enable_in_n <= 1'b0;
    tick(6);
    cmp(34'(chip_enable_out_n), 34'h1);
    final_report();
  end
endmodule : supply_supervisor_watchdog_tb_top
bind supply_supervisor_watchdog supervisor_chk #(.RESET_CYCLES(RESET_CYCLES)) u_supervisor_chk (.*);
